/* File: smcc_host.sv */
`timescale 1ns/1ps
// ----------------------------------------
// smbus master model, the far side of the serial port
// ----------------------------------------
module smcc_host
	import smcc_pkg::*;
(
	input wire logic clock, // system clock
	input wire logic sda_w, // resolved data wire
	output logic scl, // serial clock, master driven
	output logic sda_m // master data drive, 1 = released
);
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
	end
	// six clocks per step keeps every phase well above the port's four clock minimum
	task automatic step();
		repeat (6) @(posedge clock);
	endtask : step
	// data moves only while the clock is low; sampled late in the high phase
	task automatic bit_io(input logic b, output logic r);
		scl <= 1'b0;
		step();
		sda_m <= b;
		step();
		scl <= 1'b1;
		repeat (5) @(posedge clock);
		@(negedge clock);
		r = sda_w;
		@(posedge clock);
	endtask : bit_io
	// start or repeated start: data falls while the clock is high
	task automatic start();
		scl <= 1'b0;
		step();
		sda_m <= 1'b1;
		step();
		scl <= 1'b1;
		step();
		sda_m <= 1'b0;
		step();
	endtask : start
	task automatic stop();
		scl <= 1'b0;
		step();
		sda_m <= 1'b0;
		step();
		scl <= 1'b1;
		step();
		sda_m <= 1'b1;
		step();
	endtask : stop
	// eight bits msb first, then the acknowledge slot driven with m9
	task automatic xfer(input logic [7:0] o, input logic m9, output logic [7:0] i,
		output logic a);
		for (int k = 7; k >= 0; k--) begin
			bit_io(o[k], i[k]);
		end
		bit_io(m9, a);
	endtask : xfer
	// write word: address byte, command, low byte, high byte
	task automatic write_word(input logic [7:0] ab, input logic [7:0] c,
		input logic [15:0] d, output logic [3:0] ak);
		logic [7:0] x;
		start();
		xfer(ab, 1'b1, x, ak[0]);
		xfer(c, 1'b1, x, ak[1]);
		xfer(d[7:0], 1'b1, x, ak[2]);
		xfer(d[15:8], 1'b1, x, ak[3]);
		stop();
	endtask : write_word
	// read word: command by write address, repeated start, read address, two bytes
	task automatic read_word(input logic [7:0] c, output logic [15:0] v,
		output logic [2:0] ak);
		logic [7:0] x;
		logic n;
		start();
		xfer({TARGET_ADDR, 1'b0}, 1'b1, x, ak[0]);
		xfer(c, 1'b1, x, ak[1]);
		start();
		xfer({TARGET_ADDR, 1'b1}, 1'b1, x, ak[2]);
		xfer(8'hFF, 1'b0, v[7:0], n);
		xfer(8'hFF, 1'b1, v[15:8], n);
		stop();
	endtask : read_word
endmodule : smcc_host

/* File: smcc_pkg.sv */
package smcc_pkg;
	// ----------------------------------------
	// bus identity and command codes
	// ----------------------------------------
	localparam logic [6:0] TARGET_ADDR = 7'h09;
	localparam logic [7:0] CMD_CHG_CURRENT = 8'h14;
	localparam logic [7:0] CMD_CHG_VOLTAGE = 8'h15;
	localparam logic [15:0] READ_FILL = 16'hFFFF;
	// ----------------------------------------
	// values after reset and linear clamp limits
	// ----------------------------------------
	localparam logic [15:0] CUR_RST = 16'h00C0;
	localparam logic [15:0] VOLT_RST = 16'hFFF0;
	localparam logic [4:0] LIN_MAX = 5'h1F;
	localparam logic [15:0] LIN_LIMIT = 16'h0020;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int LIN_LSB = 0;
	localparam int SW_LSB = 5;
	localparam int VDAC_LSB = 4;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_HZ = 25000000;
	localparam int CLK_NS = 40;
	localparam int SW_FREQ_HZ = 250000;
	localparam int PWM_PERIOD = CLK_HZ / SW_FREQ_HZ;
	localparam int DEAD_NS = 80;
	localparam int DEAD_CYC_I = (DEAD_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [3:0] DEAD_CYC = 4'(DEAD_CYC_I < 1 ? 1 : DEAD_CYC_I);
	localparam logic [6:0] PWM_LAST = 7'(PWM_PERIOD - 1);
	// ----------------------------------------
	// serial port states
	// ----------------------------------------
	typedef enum logic [5:0] {
		ST_IDLE = 6'b000001,
		ST_RX = 6'b000010,
		ST_ACK = 6'b000100,
		ST_TX = 6'b001000,
		ST_MACK = 6'b010000,
		ST_WAIT = 6'b100000
	} smcc_state_t;
endpackage : smcc_pkg

/* File: smcc_top.sv */
`timescale 1ns/1ps
// How it works
// R1: low five bits linear, high six switcher
// R2: linear source steps one milliamp per code
// R3: code 32 and above pins linear 31
// R4: fixed switching period, only duty varies
// R5: zero inductor current turns rectifier off
// R6: dead time between the two gates
// R7: target only, never starts a transfer
// R8: exchanges are read-word or write-word
// R9: master opens with start then address
// R10: answers address 0001001, bytes 0x12/0x13
// R11: other addresses ignored, bus left released
// R12: voltage write drops four bits, loads ten
module smcc_top
	import smcc_pkg::*;
(
	input wire logic clock, // 25 MHz system clock
	input wire logic sys_rst, // synchronous reset, high
	input wire logic scl_in, // serial clock pin
	input wire logic sda_in, // serial data pin level
	output logic sda_out, // serial data drive value
	output logic sda_oe, // serial data drive enable
	input wire logic zero_cur_in, // inductor current at zero
	input wire logic [6:0] duty_cmd, // on-time from loop, same clock
	output logic [4:0] lin_code, // linear source code, 1 mA/step
	output logic [5:0] sw_code, // switcher current dac code
	output logic [9:0] volt_code, // voltage dac code, 16 mV/step
	output logic hs_gate, // high-side switch drive
	output logic ls_gate // rectifier drive
);
	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic scl_m_reg, scl_s_reg, scl_d_reg;
	logic sda_m_reg, sda_s_reg, sda_d_reg;
	logic zc_m_reg, zc_s_reg;
	// first stage is read only by the second
	always_ff @(posedge clock) begin
		scl_m_reg <= scl_in;
		scl_s_reg <= scl_m_reg;
		scl_d_reg <= scl_s_reg;
		sda_m_reg <= sda_in;
		sda_s_reg <= sda_m_reg;
		sda_d_reg <= sda_s_reg;
		zc_m_reg <= zero_cur_in;
		zc_s_reg <= zc_m_reg;
	end

	// bus events from the settled copies
	wire scl_rise = scl_s_reg & ~scl_d_reg;
	wire scl_fall = ~scl_s_reg & scl_d_reg;
	wire start_ev = scl_s_reg & scl_d_reg & sda_d_reg & ~sda_s_reg; // see R9
	wire stop_ev = scl_s_reg & scl_d_reg & ~sda_d_reg & sda_s_reg;

	// ----------------------------------------
	// serial target
	// ----------------------------------------
	smcc_state_t state_reg;
	logic [3:0] bit_cnt_reg;
	logic [1:0] byte_idx_reg;
	logic [7:0] rx_sh_reg, tx_sh_reg, cmd_reg, dlo_reg;
	logic rd_mode_reg, hi_sent_reg, mack_reg, oe_reg;
	logic [15:0] cur_reg, volt_reg;

	// byte decode done on the falling edge after the eighth bit
	wire byte_done = scl_fall & (bit_cnt_reg == 4'h8);
	wire addr_wr = rx_sh_reg == {TARGET_ADDR, 1'b0}; // see R10
	wire addr_rd = rx_sh_reg == {TARGET_ADDR, 1'b1}; // see R10
	wire [15:0] rd_word = (cmd_reg == CMD_CHG_CURRENT) ? cur_reg :
		(cmd_reg == CMD_CHG_VOLTAGE) ? volt_reg : READ_FILL;
	wire commit = (state_reg == ST_RX) & byte_done & (byte_idx_reg == 2'h3);

	// one process so start and stop override every state in one place
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state_reg <= ST_IDLE;
			bit_cnt_reg <= 4'h0;
			byte_idx_reg <= 2'h0;
			rx_sh_reg <= 8'h00;
			tx_sh_reg <= 8'h00;
			cmd_reg <= 8'h00;
			dlo_reg <= 8'h00;
			rd_mode_reg <= 1'b0;
			hi_sent_reg <= 1'b0;
			mack_reg <= 1'b1;
			oe_reg <= 1'b0;
		end else if (start_ev) begin // also a repeated start
			state_reg <= ST_RX;
			bit_cnt_reg <= 4'h0;
			byte_idx_reg <= 2'h0;
			oe_reg <= 1'b0;
		end else if (stop_ev) begin
			state_reg <= ST_IDLE;
			oe_reg <= 1'b0;
		end else begin
			case (state_reg)
				ST_RX: begin
					if (scl_rise) begin
						rx_sh_reg <= {rx_sh_reg[6:0], sda_s_reg};
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					end else if (byte_done) begin
						if (byte_idx_reg == 2'h0 && !(addr_wr || addr_rd)) begin
							state_reg <= ST_WAIT; // see R11
						end else begin
							state_reg <= ST_ACK;
							oe_reg <= 1'b1;
							if (byte_idx_reg == 2'h0) begin
								rd_mode_reg <= addr_rd;
							end
							if (byte_idx_reg == 2'h1) begin
								cmd_reg <= rx_sh_reg;
							end
							if (byte_idx_reg == 2'h2) begin
								dlo_reg <= rx_sh_reg;
							end
						end
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						bit_cnt_reg <= 4'h0;
						if (rd_mode_reg && byte_idx_reg == 2'h0) begin
							// read word: low byte leaves first
							state_reg <= ST_TX; // see R8
							tx_sh_reg <= rd_word[7:0];
							oe_reg <= ~rd_word[7];
							hi_sent_reg <= 1'b0;
						end else if (byte_idx_reg == 2'h3) begin
							state_reg <= ST_WAIT; // a fifth byte is not taken
							oe_reg <= 1'b0;
						end else begin
							state_reg <= ST_RX;
							byte_idx_reg <= byte_idx_reg + 2'h1;
							oe_reg <= 1'b0;
						end
					end
				end
				ST_TX: begin
					if (scl_rise) begin
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					end else if (byte_done) begin
						state_reg <= ST_MACK;
						oe_reg <= 1'b0;
					end else if (scl_fall) begin
						tx_sh_reg <= {tx_sh_reg[6:0], 1'b1};
						oe_reg <= ~tx_sh_reg[6];
					end
				end
				ST_MACK: begin
					if (scl_rise) begin
						mack_reg <= sda_s_reg;
					end else if (scl_fall) begin
						if (!mack_reg && !hi_sent_reg) begin
							state_reg <= ST_TX;
							bit_cnt_reg <= 4'h0;
							tx_sh_reg <= rd_word[15:8];
							oe_reg <= ~rd_word[15];
							hi_sent_reg <= 1'b1;
						end else begin
							state_reg <= ST_WAIT;
						end
					end
				end
				ST_IDLE, ST_WAIT: begin
					oe_reg <= 1'b0;
				end
				default: begin
					state_reg <= ST_IDLE;
					oe_reg <= 1'b0;
				end
			endcase
		end
	end

	// open-drain: only ever pulls low, and only as an addressed target
	assign sda_out = 1'b0; // see R7
	assign sda_oe = oe_reg;

	// ----------------------------------------
	// setting words and dac codes
	// ----------------------------------------
	wire wr_cur = commit & (cmd_reg == CMD_CHG_CURRENT);
	wire wr_volt = commit & (cmd_reg == CMD_CHG_VOLTAGE);
	wire [15:0] wr_word = {rx_sh_reg, dlo_reg};
	// values past the 11-bit range saturate the switcher code
	wire [5:0] sw_next = (cur_reg[15:11] != 5'h00) ? 6'h3F : cur_reg[10:SW_LSB]; // see R1
	// keeps the total monotonic whatever the sense path offset
	wire [4:0] lin_next = (cur_reg >= LIN_LIMIT) ? LIN_MAX : cur_reg[LIN_LSB +: 5]; // see R2 R3
	// the two top bits force full scale
	wire [9:0] volt_next = (volt_reg[15:14] != 2'b00) ? 10'h3FF : volt_reg[13:VDAC_LSB]; // see R12

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			cur_reg <= CUR_RST;
			volt_reg <= VOLT_RST;
		end else begin
			if (wr_cur) cur_reg <= wr_word;
			if (wr_volt) volt_reg <= wr_word; // see R12
		end
	end

	always_ff @(posedge clock) begin
		lin_code <= lin_next; // see R1
		sw_code <= sw_next; // see R1
		volt_code <= volt_next;
	end

	// ----------------------------------------
	// switching period and gate drive
	// ----------------------------------------
	logic [6:0] pwm_cnt_reg;
	logic [3:0] dead_cnt_reg;
	logic hs_reg, ls_reg;

	// the period never moves; the loop only sets on-time
	wire hs_want = pwm_cnt_reg < duty_cmd; // see R4
	wire ls_want = ~hs_want & ~zc_s_reg; // see R5
	wire dead_zero = dead_cnt_reg == 4'h0;
	wire hs_next = hs_want & ~ls_reg & (hs_reg | dead_zero); // see R6
	wire ls_next = ls_want & ~hs_reg & (ls_reg | dead_zero); // see R6
	wire gate_off = (hs_reg & ~hs_next) | (ls_reg & ~ls_next);

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			pwm_cnt_reg <= 7'h00;
			dead_cnt_reg <= DEAD_CYC;
			hs_reg <= 1'b0;
			ls_reg <= 1'b0;
		end else begin
			pwm_cnt_reg <= (pwm_cnt_reg == PWM_LAST) ? 7'h00 : pwm_cnt_reg + 7'h01; // see R4
			dead_cnt_reg <= gate_off ? DEAD_CYC : (dead_zero ? 4'h0 : dead_cnt_reg - 4'h1);
			hs_reg <= hs_next;
			ls_reg <= ls_next;
		end
	end

	assign hs_gate = hs_reg;
	assign ls_gate = ls_reg;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	sequence hs_drop_s;
		hs_reg ##1 !hs_reg;
	endsequence
	sequence ls_drop_s;
		ls_reg ##1 !ls_reg;
	endsequence

	// expectations come from the word fields, not from the split logic itself
	switch_split_a: assert property ((cur_reg[15:11] == 5'h00) // see R1
		|=> sw_code == $past(cur_reg[10:5]))
		else $error("switcher code does not follow current word");
	switch_sat_a: assert property ((cur_reg[15:11] != 5'h00) |=> sw_code == 6'h3F) // see R1
		else $error("switcher code not saturated");
	lin_cap_a: assert property ((cur_reg >= LIN_LIMIT) |=> lin_code == LIN_MAX) // see R3
		else $error("linear code not capped at 31");
	lin_follow_a: assert property ((cur_reg < LIN_LIMIT) |=> lin_code == $past(cur_reg[4:0])) // see R2
		else $error("linear code does not follow low bits");
	period_fixed_a: assert property ((pwm_cnt_reg == PWM_LAST) |=> pwm_cnt_reg == 7'h00) // see R4
		else $error("switching period changed");
	zero_cur_a: assert property (zc_s_reg |=> !ls_reg) // see R5
		else $error("rectifier on at zero current");
	no_overlap_a: assert property (!(hs_reg && ls_reg)) // see R6
		else $error("both switches on");
	dead_hl_a: assert property (hs_drop_s |-> !ls_reg [*2]) // see R6
		else $error("rectifier on inside dead time");
	dead_lh_a: assert property (ls_drop_s |-> !hs_reg [*2]) // see R6
		else $error("high side on inside dead time");
	idle_quiet_a: assert property ((state_reg == ST_IDLE) |-> !sda_oe) // see R7
		else $error("bus driven while not addressed");
	addr_ack_a: assert property ((state_reg == ST_RX && byte_done && byte_idx_reg == 2'h0
		&& rx_sh_reg[7:1] == TARGET_ADDR && !start_ev && !stop_ev) |=> sda_oe) // see R10
		else $error("own address not acknowledged");
	addr_skip_a: assert property ((state_reg == ST_RX && byte_done && byte_idx_reg == 2'h0
		&& rx_sh_reg[7:1] != TARGET_ADDR) |=> !sda_oe [*2]) // see R11
		else $error("foreign address acknowledged");
	volt_load_a: assert property ((wr_volt && !start_ev && !stop_ev && rx_sh_reg[7:6] == 2'b00)
		|-> ##2 volt_code == $past({rx_sh_reg[5:0], dlo_reg[7:4]}, 2)) // see R12 R8
		else $error("voltage dac not loaded from data bits");
endmodule : smcc_top

/* File: tb_top.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; \
	$display("Error t=%0t got %h exp %h", $time, (g), (e)); end end
module tb_top;
	import smcc_pkg::*;
	logic clock, sys_rst, zero_cur_in, sda_out, sda_oe, hs_gate, ls_gate, scl, sda_m;
	logic hs_q, ls_q, per_on;
	logic [4:0] zh;
	logic [6:0] duty_cmd;
	logic [4:0] lin_code;
	logic [5:0] sw_code;
	logic [9:0] volt_code;
	logic [15:0] rv;
	logic [3:0] ak;
	wire sda_w;
	int failures, compares, cyc, hs_per, hs_off, ls_off, cur_m, volt_m;
	// boundaries of the linear clamp, the switcher field and the voltage override
	int cur_v[7] = '{31, 32, 33, 0, 2047, 2048, 16'hFFFF};
	int volt_v[3] = '{16'h3FFF, 16'h4000, 16'h000F};
	logic [7:0] x8;
	// open drain wire: low if either party pulls
	assign sda_w = sda_m & ~(sda_oe & ~sda_out);
	smcc_top DUT (.clock(clock), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda_w),
		.sda_out(sda_out), .sda_oe(sda_oe), .zero_cur_in(zero_cur_in), .duty_cmd(duty_cmd),
		.lin_code(lin_code), .sw_code(sw_code), .volt_code(volt_code), .hs_gate(hs_gate),
		.ls_gate(ls_gate));
	smcc_host host (.clock(clock), .sda_w(sda_w), .scl(scl), .sda_m(sda_m));
	always #20 clock = ~clock;
	task automatic results();
		if (failures == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : results
	// ----------------------------------------
	// gate monitor and hang guard
	// ----------------------------------------
	always @(posedge clock) begin
		if (!sys_rst) begin
			`CHK(hs_gate & ls_gate, 1'b0)
			if (ls_gate && !ls_q) `CHK(hs_off >= 3, 1'b1)
			if (hs_gate && !hs_q) `CHK(ls_off >= 3, 1'b1)
			if (hs_gate && !hs_q && per_on) `CHK(hs_per, PWM_PERIOD)
			if (&zh) `CHK(ls_gate, 1'b0)
		end
		hs_per = (hs_gate && !hs_q) ? 1 : hs_per + 1;
		hs_off = hs_gate ? 0 : hs_off + 1;
		ls_off = ls_gate ? 0 : ls_off + 1;
		hs_q = hs_gate;
		ls_q = ls_gate;
		zh = {zh[3:0], zero_cur_in};
		// hang guard last, so nothing in this block runs after the verdict
		cyc++;
		if (cyc > 80000) begin
			failures++;
			results();
		end
	end
	// model of the setting words and their dac split
	task automatic chk_outs();
		`CHK(lin_code, (cur_m >= 32) ? 5'h1F : 5'(cur_m))
		`CHK(sw_code, (cur_m >> 11) != 0 ? 6'h3F : 6'(cur_m >> 5))
		`CHK(volt_code, (volt_m >> 14) != 0 ? 10'h3FF : 10'(volt_m >> 4))
	endtask : chk_outs
	task automatic wr(input logic [7:0] a, input logic [7:0] c, input int d);
		logic own;
		own = (a == {TARGET_ADDR, 1'b0});
		host.write_word(a, c, 16'(d), ak);
		`CHK(ak, own ? 4'h0 : 4'hF)
		if (own && c == CMD_CHG_CURRENT) cur_m = d & 16'hFFFF;
		if (own && c == CMD_CHG_VOLTAGE) volt_m = d & 16'hFFFF;
		repeat (3) @(posedge clock);
		chk_outs();
	endtask : wr
	task automatic rd(input logic [7:0] c);
		logic [2:0] a3;
		host.read_word(c, rv, a3);
		`CHK(a3, 3'h0)
		`CHK(rv, c == CMD_CHG_CURRENT ? 16'(cur_m) : c == CMD_CHG_VOLTAGE ? 16'(volt_m)
			: READ_FILL)
	endtask : rd
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		clock = 1'b0;
		sys_rst = 1'b1;
		zero_cur_in = 1'b0;
		per_on = 1'b0;
		zh = 5'h00;
		void'($urandom(16170));
		duty_cmd = 7'(10 + $urandom % 80);
		repeat (3) @(posedge clock);
		sys_rst <= 1'b0;
		repeat (300) @(posedge clock);
		per_on <= 1'b1;
		cur_m = 16'h00C0;
		volt_m = 16'hFFF0;
		chk_outs();
		rd(CMD_CHG_CURRENT);
		rd(CMD_CHG_VOLTAGE);
		// boundaries of the linear clamp and of the switcher field
		foreach (cur_v[i]) begin
			wr({TARGET_ADDR, 1'b0}, CMD_CHG_CURRENT, cur_v[i]);
		end
		foreach (volt_v[i]) begin
			wr({TARGET_ADDR, 1'b0}, CMD_CHG_VOLTAGE, volt_v[i]);
		end
		for (int n = 0; n < 6; n++) begin
			wr({TARGET_ADDR, 1'b0}, CMD_CHG_CURRENT, $urandom % 65536);
			rd(CMD_CHG_CURRENT);
			wr({TARGET_ADDR, 1'b0}, CMD_CHG_VOLTAGE, $urandom % 65536);
			rd(CMD_CHG_VOLTAGE);
		end
		// foreign address and unknown command leave the settings alone
		wr({TARGET_ADDR ^ 7'h03, 1'b0}, CMD_CHG_CURRENT, 5);
		wr({TARGET_ADDR, 1'b0}, 8'h16, 1234);
		rd(8'h16);
		rd(CMD_CHG_CURRENT);
		// a write cut after the low byte stores nothing
		host.start();
		host.xfer({TARGET_ADDR, 1'b0}, 1'b1, x8, ak[0]);
		host.xfer(CMD_CHG_CURRENT, 1'b1, x8, ak[1]);
		host.xfer(8'h55, 1'b1, x8, ak[2]);
		host.stop();
		`CHK(ak[2:0], 3'h0)
		rd(CMD_CHG_CURRENT);
		// gate stress: duty every cycle, zero current in bursts
		per_on <= 1'b0;
		repeat (3000) begin
			@(posedge clock);
			duty_cmd <= 7'($urandom % 100);
			if ($urandom % 8 == 0) zero_cur_in <= 1'($urandom % 2);
		end
		// a second reset mid-run brings back the power-up words
		sys_rst <= 1'b1;
		repeat (3) @(posedge clock);
		sys_rst <= 1'b0;
		repeat (10) @(posedge clock);
		cur_m = CUR_RST;
		volt_m = VOLT_RST;
		chk_outs();
		rd(CMD_CHG_VOLTAGE);
		results();
	end
endmodule : tb_top
